// [common/occ_params.svh]
// Register offsets, field positions, reset values and timing counts for the clock control block.
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH
`define OCC_RC_OFF          12'h020
`define OCC_LOOP_OFF        12'h024
`define OCC_STAT_OFF        12'h00C
`define OCC_RC_RESET        32'h87070382
`define OCC_LOOP_RESET      16'h0080
`define OCC_RC_WMASK        32'h0FFF03C2
`define OCC_LOOP_WMASK      16'h0FDE
`define OCC_TRIM_LSB        16
`define OCC_TRIM_MSB        27
`define OCC_DIV_LSB         8
`define OCC_DIV_MSB         9
`define OCC_REQGATE_BIT     7
`define OCC_KEEPRUN_BIT     6
`define OCC_EN_BIT          1
`define OCC_HOLDLOCK_BIT    11
`define OCC_SKIPCOARSE_BIT  10
`define OCC_FASTOFF_BIT     9
`define OCC_COOLOFF_BIT     8
`define OCC_DROPLOCK_BIT    4
`define OCC_STABLE_BIT      3
`define OCC_MODE_BIT        2
`define OCC_STARTUP_NS      80
`define OCC_STARTUP_CYC     ((`OCC_STARTUP_NS + 9) / 10)
`define OCC_SYNC_NS         40
`define OCC_SYNC_CYC        ((`OCC_SYNC_NS + 9) / 10)
`endif

// [common/occ_pkg.sv]
// Types shared by the clock control block.
package occ_pkg;
	typedef enum logic [3:0] {
		OCC_OFF      = 4'b0001,
		OCC_STARTING = 4'b0010,
		OCC_ON       = 4'b0100,
		OCC_STOPPING = 4'b1000
	} occ_rc_state_t;
	typedef logic [1:0] occ_div_t;
endpackage

// [common/occ_div_if.sv]
// Interface that carries the divider setting and the divided output.
`timescale 1ns/1ps
interface occ_div_if;
	logic             run;
	occ_pkg::occ_div_t sel;
	logic             tick;
	modport ctrl (output run, output sel, input tick);
	modport div  (input run, input sel, output tick);
endinterface

// [verilog/occ_divider.sv]
// Output divider of the RC oscillator.
`timescale 1ns/1ps
module occ_divider (
	// Clock and reset.
	input  wire logic aclk,
	input  wire logic aresetn,
	// Divider control.
	occ_div_if.div    dv
);
	import occ_pkg::*;
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic       tick;
	logic       next_tick;

	// Counts cycles and pulses once every 1, 2, 4 or 8 cycles.
	always_comb begin
		logic [2:0] top;
		top = 3'((4'h1 << dv.sel) - 4'h1);
		next_cnt = cnt;
		next_tick = 1'b0;
		if (!dv.run) begin
			next_cnt = 3'h0;
		end else if (cnt >= top) begin
			next_cnt = 3'h0;
			next_tick = 1'b1;
		end else begin
			next_cnt = cnt + 3'h1;
		end
	end

	// Registers the divider state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 3'h0;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
	assign dv.tick = tick;

	property p_div8;
		@(posedge aclk) disable iff (!aresetn)
		(dv.run && dv.sel == 2'h3 && tick) ##1 (dv.run && dv.sel == 2'h3) [*7]
			|-> !tick;
	endproperty
	a_div8: assert property (p_div8) else $error("Divide by eight ticked early.");
endmodule

// [verilog/occ_clock_ctrl.sv]
// Control registers and run gating of the RC and loop oscillators.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "occ_params.svh"
module occ_clock_ctrl #(
	parameter logic [11:0] TRIM_FACTORY = 12'h707
) (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write channels.
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// System inputs from outside the clock domain.
	input  wire logic        rc_clock_request,
	input  wire logic        loop_clock_request,
	input  wire logic        standby_sleep,
	input  wire logic        loop_locked,
	// RC oscillator controls.
	output logic             rc_run,
	output logic [11:0]      rc_trim,
	output logic             rc_divided_tick,
	// Loop oscillator controls.
	output logic             loop_run,
	output logic             loop_output_gate,
	output logic             loop_hold_until_locked,
	output logic             loop_skip_coarse,
	output logic             loop_fast_acquire,
	output logic             loop_cool_cycles,
	output logic             loop_drop_locks,
	output logic             loop_freeze_fine,
	output logic             loop_closed_loop
);
	import occ_pkg::*;

	localparam int STARTUP_CYC = `OCC_STARTUP_CYC;
	localparam int SYNC_CYC    = `OCC_SYNC_CYC;
	localparam logic [31:0] RC_RESET = `OCC_RC_RESET & `OCC_RC_WMASK;

	// Two-flop synchronisers for asynchronous inputs.
	logic [3:0] sync1;
	logic [3:0] sync2;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= {loop_locked, standby_sleep, loop_clock_request, rc_clock_request};
			sync2 <= sync1;
		end
	end
	logic rc_req;
	logic lp_req;
	logic asleep;
	logic locked;
	assign rc_req = sync2[0];
	assign lp_req = sync2[1];
	assign asleep = sync2[2];
	assign locked = sync2[3];

	// Decides whether an oscillator runs from enable, gating and sleep.
	function automatic logic want_run(input logic en, input logic gated, input logic keep,
			input logic req, input logic slp);
		logic r;
		r = en && (!gated || req);
		if (slp && !keep) begin
			r = 1'b0;
		end
		return r;
	endfunction

	// Register state.
	logic [31:0]   rc_reg;
	logic [15:0]   loop_reg;
	occ_rc_state_t rc_st;
	logic [3:0]    rc_cnt;
	logic          loop_en_act;
	logic [3:0]    sync_cnt;
	logic          loop_ready;
	logic          loop_stopped;
	logic          aw_hold;
	logic [11:0]   aw_addr;
	logic          w_hold;
	logic [31:0]   w_data;
	logic          bvalid;
	logic [1:0]    bresp;
	logic          rvalid;
	logic [31:0]   rdata;
	logic [1:0]    rresp;
	logic [31:0]   next_rc_reg;
	logic [15:0]   next_loop_reg;
	occ_rc_state_t next_rc_st;
	logic [3:0]    next_rc_cnt;
	logic          next_loop_en_act;
	logic [3:0]    next_sync_cnt;
	logic          next_loop_ready;
	logic          next_loop_stopped;
	logic          next_aw_hold;
	logic [11:0]   next_aw_addr;
	logic          next_w_hold;
	logic [31:0]   next_w_data;
	logic          next_bvalid;
	logic [1:0]    next_bresp;
	logic          next_rvalid;
	logic [31:0]   next_rdata;
	logic [1:0]    next_rresp;
	logic          do_write;
	logic          rc_want;
	logic          lp_want;

	assign s_axi_awready = !aw_hold && !bvalid;
	assign s_axi_wready  = !w_hold && !bvalid;
	assign s_axi_arready = !rvalid;
	assign do_write = aw_hold && w_hold && !bvalid;

	// Computes next values for registers, oscillator states and bus channels.
	always_comb begin
		logic [31:0] wd;
		wd = w_data;
		next_rc_reg = rc_reg;
		next_loop_reg = loop_reg;
		next_rc_st = rc_st;
		next_rc_cnt = rc_cnt;
		next_loop_en_act = loop_en_act;
		next_sync_cnt = sync_cnt;
		next_loop_ready = loop_ready;
		next_loop_stopped = loop_stopped;
		next_aw_hold = aw_hold;
		next_aw_addr = aw_addr;
		next_w_hold = w_hold;
		next_w_data = w_data;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		rc_want = 1'b0;
		lp_want = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		// Loop enable takes effect after the synchronisation delay.
		// Counted before the write decode so that a new enable change restarts the count.
		if (sync_cnt != 4'h0) begin
			next_sync_cnt = sync_cnt - 4'h1;
			if (sync_cnt == 4'h1) begin
				next_loop_en_act = loop_reg[`OCC_EN_BIT];
				next_loop_ready = 1'b1;
			end
		end
		// Write decode; reserved bits are masked off.
		if (do_write) begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = 2'h0;
			if (aw_addr == `OCC_RC_OFF) begin
				next_rc_reg = wd & `OCC_RC_WMASK;
			end else if (aw_addr == `OCC_LOOP_OFF) begin
				next_loop_reg = wd[15:0] & `OCC_LOOP_WMASK;
				if (wd[`OCC_EN_BIT] != loop_reg[`OCC_EN_BIT]) begin
					next_sync_cnt = 4'(SYNC_CYC);
					next_loop_ready = 1'b0;
				end
			end else if (aw_addr == `OCC_STAT_OFF) begin
				next_bresp = 2'h0;
			end else begin
				next_bresp = 2'h2;
			end
		end
		// RC oscillator start and stop sequencing.
		rc_want = want_run(rc_reg[`OCC_EN_BIT], rc_reg[`OCC_REQGATE_BIT],
			rc_reg[`OCC_KEEPRUN_BIT], rc_req, asleep);
		case (rc_st)
			OCC_OFF: begin
				if (rc_want) begin
					next_rc_st = OCC_STARTING;
					next_rc_cnt = 4'(STARTUP_CYC);
				end
			end
			OCC_STARTING: begin
				if (rc_cnt <= 4'h1) begin
					next_rc_st = OCC_ON;
				end else begin
					next_rc_cnt = rc_cnt - 4'h1;
				end
			end
			OCC_ON: begin
				if (!rc_want) begin
					next_rc_st = OCC_STOPPING;
					next_rc_cnt = 4'(STARTUP_CYC);
				end
			end
			OCC_STOPPING: begin
				if (rc_cnt <= 4'h1) begin
					next_rc_st = OCC_OFF;
				end else begin
					next_rc_cnt = rc_cnt - 4'h1;
				end
			end
			default: begin
				next_rc_st = OCC_OFF;
			end
		endcase
		// Loop oscillator gating and stop tracking for lock loss on wake.
		lp_want = want_run(loop_en_act, loop_reg[`OCC_REQGATE_BIT],
			loop_reg[`OCC_KEEPRUN_BIT], lp_req, asleep);
		if (asleep && !lp_want && loop_en_act) begin
			next_loop_stopped = 1'b1;
		end else if (!asleep) begin
			next_loop_stopped = 1'b0;
		end
		// Read decode.
		if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = 2'h0;
			if (s_axi_araddr == `OCC_RC_OFF) begin
				next_rdata = rc_reg;
				// Enable reads one while on or stopping, zero while off or starting.
				next_rdata[`OCC_EN_BIT] = (rc_st == OCC_ON) || (rc_st == OCC_STOPPING);
			end else if (s_axi_araddr == `OCC_LOOP_OFF) begin
				next_rdata = {16'h0000, loop_reg};
			end else if (s_axi_araddr == `OCC_STAT_OFF) begin
				next_rdata = {29'h0, loop_en_act, loop_ready, rc_st == OCC_ON};
			end else begin
				next_rdata = 32'h00000000;
				next_rresp = 2'h2;
			end
		end
	end

	// Registers the control, sequencing and bus state; the trim field preloads from factory calibration.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_reg <= {RC_RESET[31:`OCC_TRIM_MSB + 1], TRIM_FACTORY, RC_RESET[`OCC_TRIM_LSB - 1:0]};
			loop_reg <= `OCC_LOOP_RESET;
			rc_st <= OCC_OFF;
			rc_cnt <= 4'h0;
			loop_en_act <= 1'b0;
			sync_cnt <= 4'h0;
			loop_ready <= 1'b1;
			loop_stopped <= 1'b0;
			aw_hold <= 1'b0;
			aw_addr <= 12'h000;
			w_hold <= 1'b0;
			w_data <= 32'h00000000;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'h0;
		end else begin
			rc_reg <= next_rc_reg;
			loop_reg <= next_loop_reg;
			rc_st <= next_rc_st;
			rc_cnt <= next_rc_cnt;
			loop_en_act <= next_loop_en_act;
			sync_cnt <= next_sync_cnt;
			loop_ready <= next_loop_ready;
			loop_stopped <= next_loop_stopped;
			aw_hold <= next_aw_hold;
			aw_addr <= next_aw_addr;
			w_hold <= next_w_hold;
			w_data <= next_w_data;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// Trim preload at first clocked cycle after reset release.
	logic trim_loaded;
	logic next_trim_loaded;
	logic [11:0] trim_init;
	always_comb begin
		next_trim_loaded = 1'b1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trim_loaded <= 1'b0;
		end else begin
			trim_loaded <= next_trim_loaded;
		end
	end
	assign trim_init = TRIM_FACTORY;

	// Output drives from registered state.
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign rc_run = (rc_st != OCC_OFF);
	assign rc_trim = trim_loaded ? rc_reg[`OCC_TRIM_MSB:`OCC_TRIM_LSB] : trim_init;
	assign loop_run = want_run(loop_en_act, loop_reg[`OCC_REQGATE_BIT],
		loop_reg[`OCC_KEEPRUN_BIT], lp_req, asleep);
	assign loop_output_gate = loop_run && (!loop_reg[`OCC_HOLDLOCK_BIT] || locked);
	assign loop_hold_until_locked = loop_reg[`OCC_HOLDLOCK_BIT];
	assign loop_skip_coarse = loop_reg[`OCC_SKIPCOARSE_BIT];
	assign loop_fast_acquire = !loop_reg[`OCC_FASTOFF_BIT];
	assign loop_cool_cycles = !loop_reg[`OCC_COOLOFF_BIT];
	assign loop_drop_locks = loop_reg[`OCC_DROPLOCK_BIT] && loop_stopped && !asleep;
	assign loop_freeze_fine = loop_reg[`OCC_STABLE_BIT] && locked;
	assign loop_closed_loop = loop_reg[`OCC_MODE_BIT];

	// Divider of the RC output.
	occ_div_if dvi ();
	assign dvi.run = (rc_st == OCC_ON);
	assign dvi.sel = rc_reg[`OCC_DIV_MSB:`OCC_DIV_LSB];
	assign rc_divided_tick = dvi.tick;
	occ_divider u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.dv      (dvi.div)
	);

	property p_sleep_off;
		@(posedge aclk) disable iff (!aresetn)
		(asleep && !loop_reg[`OCC_KEEPRUN_BIT]) |-> !loop_run;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("Loop ran asleep.");
	property p_gated;
		@(posedge aclk) disable iff (!aresetn)
		(loop_reg[`OCC_REQGATE_BIT] && !lp_req) |-> !loop_run;
	endproperty
	a_gated: assert property (p_gated) else $error("Loop ran without request.");
	property p_free;
		@(posedge aclk) disable iff (!aresetn)
		(loop_en_act && !loop_reg[`OCC_REQGATE_BIT] && !asleep) |-> loop_run;
	endproperty
	a_free: assert property (p_free) else $error("Loop stopped while free running.");
	property p_keep;
		@(posedge aclk) disable iff (!aresetn)
		(loop_en_act && asleep && loop_reg[`OCC_KEEPRUN_BIT] && !loop_reg[`OCC_REQGATE_BIT])
			|-> loop_run;
	endproperty
	a_keep: assert property (p_keep) else $error("Loop stopped asleep with keep.");
	property p_rc_start;
		@(posedge aclk) disable iff (!aresetn)
		(rc_st == OCC_OFF && next_rc_st == OCC_STARTING) |=> (rc_st == OCC_STARTING) [*8];
	endproperty
	a_rc_start: assert property (p_rc_start) else $error("RC started too soon.");
	property p_sync;
		@(posedge aclk) disable iff (!aresetn)
		(do_write && aw_addr == `OCC_LOOP_OFF && w_data[`OCC_EN_BIT] != loop_reg[`OCC_EN_BIT])
			|=> !loop_ready ##4 loop_ready;
	endproperty
	a_sync: assert property (p_sync) else $error("Loop enable sync delay wrong.");
	property p_lock_gate;
		@(posedge aclk) disable iff (!aresetn)
		(loop_reg[`OCC_HOLDLOCK_BIT] && !locked) |-> !loop_output_gate;
	endproperty
	a_lock_gate: assert property (p_lock_gate) else $error("Output before lock.");
	property p_resv;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |-> (loop_reg[15:12] == 4'h0 && rc_reg[15:10] == 6'h00);
	endproperty
	a_resv: assert property (p_resv) else $error("Reserved bit set.");
endmodule

// [bench/tb_osc_and_loop_clock_control.sv]
// Self-checking testbench for the clock control block.
`timescale 1ns/1ps
`include "occ_params.svh"
module tb_osc_and_loop_clock_control;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000, rdata, w;
	logic [1:0]  bresp, rresp;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        rc_req = 1'b0, loop_req = 1'b0, sleep = 1'b0, locked = 1'b0;
	logic        rc_run, tick, loop_run, gate, hold, skip, fast, cool, drop, freeze, closed;
	logic [11:0] trim, t;
	logic [15:0] cfg;
	logic [33:0] exp_q[$];
	logic [33:0] exp_v;
	logic [3:0]  c;
	int          error_cnt = 0, num_checks = 0, seed = 96, cnt;

	occ_clock_ctrl #(.TRIM_FACTORY(12'h707)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rc_clock_request(rc_req), .loop_clock_request(loop_req), .standby_sleep(sleep),
		.loop_locked(locked), .rc_run(rc_run), .rc_trim(trim), .rc_divided_tick(tick),
		.loop_run(loop_run), .loop_output_gate(gate), .loop_hold_until_locked(hold),
		.loop_skip_coarse(skip), .loop_fast_acquire(fast), .loop_cool_cycles(cool),
		.loop_drop_locks(drop), .loop_freeze_fine(freeze), .loop_closed_loop(closed));

	// Free-running 100 MHz clock.
	always #5 aclk = ~aclk;

	task automatic print_verdict;
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [33:0] got, input logic [33:0] want);
		num_checks++;
		if (got !== want) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, want);
		end
	endtask

	// Full-word write; address and data are released independently when taken.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h00000000});
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask

	// Single read; the monitor compares the answer.
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask

	// RC control word with every reserved position written as zero and enable set.
	function automatic logic [31:0] rcw(logic [11:0] tv, logic [1:0] d, logic od, logic kp);
		return {4'h0, tv, 6'h00, d, od, kp, 6'h02};
	endfunction

	// Expected RC read-back with the transitional enable value.
	function automatic logic [33:0] rce(logic [31:0] v, logic b);
		return {2'b00, (v & `OCC_RC_WMASK & 32'hFFFFFFFD) | {30'h0, b, 1'b0}};
	endfunction

	// Takes the oldest expectation off the queue at every bus answer.
	always @(posedge aclk) begin
		if (bvalid && bready) begin
			exp_v = exp_q.pop_front();
			chk({bresp, 32'h00000000}, exp_v);
		end
		if (rvalid && rready) begin
			exp_v = exp_q.pop_front();
			chk({rresp, rdata}, exp_v);
		end
	end

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`OCC_RC_OFF, {2'b00, 32'h07070380});
		chk({22'h0, trim}, {22'h0, 12'h707});
		rd(`OCC_LOOP_OFF, {2'b00, 32'h00000080});
		rd(12'h010, {2'b10, 32'h00000000});
		wr(12'h010, 32'h00000001, 2'b10);
		t = 12'($random(seed));
		w = rcw(t, 2'h0, 1'b0, 1'b0);
		wr(`OCC_RC_OFF, w, 2'b00);
		rd(`OCC_RC_OFF, rce(w, 1'b0));
		chk({33'h0, rc_run}, 34'h1);
		chk({22'h0, trim}, {22'h0, t});
		repeat (20) @(posedge aclk);
		rd(`OCC_RC_OFF, rce(w, 1'b1));
		for (int d = 0; d < 4; d++) begin
			w = rcw(t, d[1:0], 1'b0, 1'b0);
			wr(`OCC_RC_OFF, w, 2'b00);
			rd(`OCC_RC_OFF, rce(w, 1'b1));
			repeat (4) @(posedge aclk);
			cnt = 0;
			repeat (64) begin
				@(posedge aclk);
				if (tick === 1'b1) cnt++;
			end
			chk(34'(cnt), 34'(64 >> d));
		end
		w = rcw(t, 2'h0, 1'b1, 1'b0);
		wr(`OCC_RC_OFF, w, 2'b00);
		rd(`OCC_RC_OFF, rce(w, 1'b1));
		repeat (20) @(posedge aclk);
		rd(`OCC_RC_OFF, rce(w, 1'b0));
		for (int k = 0; k < 16; k++) begin
			c = 4'(k);
			rc_req <= c[0];
			sleep <= c[1];
			wr(`OCC_RC_OFF, rcw(t, 2'h0, c[3], c[2]), 2'b00);
			repeat (20) @(posedge aclk);
			chk({33'h0, rc_run}, {33'h0, ~(c[1] & ~c[2]) & (~c[3] | c[0])});
		end
		rc_req <= 1'b0;
		sleep <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			cfg = (16'($random(seed)) & 16'h0F9C) | 16'h0002;
			loop_req <= i[0];
			locked <= i[1];
			wr(`OCC_LOOP_OFF, {16'h0000, cfg}, 2'b00);
			rd(`OCC_LOOP_OFF, {18'h0, cfg});
			repeat (10) @(posedge aclk);
			chk({26'h0, loop_run, gate, hold, skip, fast, cool, freeze, closed},
				{26'h0, ~cfg[7] | i[0], (~cfg[7] | i[0]) & (~cfg[11] | i[1]), cfg[11],
				cfg[10], ~cfg[9], ~cfg[8], cfg[3] & i[1], cfg[2]});
		end
		for (int k = 0; k < 2; k++) begin
			wr(`OCC_LOOP_OFF, k ? 32'h00000012 : 32'h00000002, 2'b00);
			sleep <= 1'b1;
			repeat (10) @(posedge aclk);
			chk({33'h0, loop_run}, 34'h0);
			sleep <= 1'b0;
			cnt = 0;
			repeat (6) begin
				@(posedge aclk);
				if (drop === 1'b1) cnt++;
			end
			chk(34'(cnt), 34'(k));
		end
		wr(`OCC_LOOP_OFF, 32'h00000000, 2'b00);
		rd(`OCC_STAT_OFF, {2'b00, 32'h00000004});
		repeat (10) @(posedge aclk);
		chk({33'h0, loop_run}, 34'h0);
		rd(`OCC_STAT_OFF, {2'b00, 32'h00000002});
		repeat (4) @(posedge aclk);
		print_verdict();
	end
endmodule
